// ### rtl/board_bus_pkg.sv
package board_bus_pkg;
  // Bus widths
  localparam int DATA_W = 8;
  localparam int LOW_ADDR_W = 5;
  localparam int TICK_W = 16;
  localparam int ACC_RST_W = 64;
  localparam int DLY_RST_W = 16;
  localparam int PHS_RST_W = 2;
  localparam int SERIAL_W = 14;
  localparam int SLOT_ID_W = 16;
  localparam int LAMP_W = 2;
  localparam int FANOUT_W = 31;
  localparam int SEL_IDX_W = 4;
  localparam int NUM_SELECTS = 148;
  localparam int NUM_DIR_LINES = 19;
  localparam int STRAP_W = SERIAL_W + SLOT_ID_W + 1;

  // Register byte offsets inside the interface part
  localparam logic [4:0] OFF_ACC_RST0 = 5'h00;
  localparam int ACC_RST_BYTES = 8;
  localparam logic [4:0] OFF_DLY_RST_LO = 5'h08;
  localparam logic [4:0] OFF_DLY_RST_HI = 5'h09;
  localparam logic [4:0] OFF_MISC_RST = 5'h0A;
  localparam logic [4:0] OFF_INT_SEL = 5'h0B;
  localparam logic [4:0] OFF_LAMP = 5'h0C;
  localparam logic [4:0] OFF_POWER = 5'h0D;
  localparam logic [4:0] OFF_SERIAL_LO = 5'h10;
  localparam logic [4:0] OFF_SERIAL_HI = 5'h11;
  localparam logic [4:0] OFF_SLOT_LO = 5'h12;
  localparam logic [4:0] OFF_SLOT_HI = 5'h13;
  localparam logic [4:0] OFF_TICK_LO = 5'h14;
  localparam logic [4:0] OFF_TICK_HI = 5'h15;

  // Field positions in the misc reset register
  localparam int BIT_GIGABIT_RST = 0;
  localparam int BIT_PHASE_RST0 = 1;

  // Reset values: reset lines held asserted (low) until software releases them
  localparam logic [7:0] RST_BYTE_INIT = 8'h00;
  localparam logic [3:0] INT_SEL_INIT = 4'h0;
  localparam logic [1:0] LAMP_OFF = 2'b00;
  localparam logic [1:0] LAMP_RED = 2'b01;
  localparam logic [1:0] LAMP_GREEN = 2'b10;
  localparam logic [1:0] LAMP_YELLOW = 2'b11;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Decode part: interface part select and phasing unit selects
  localparam logic [7:0] SEL_INTERFACE = 8'h00;
  localparam logic [7:0] SEL_PHASE_UPPER = 8'h92;
  localparam logic [7:0] SEL_PHASE_LOWER = 8'h93;
endpackage

// ### rtl/bus_decode.sv
`timescale 1ns/1ps
module bus_decode (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic board_select_n_i,
  input wire logic [7:0] upper_address_byte_i,
  input wire logic read_not_write_i,
  output logic [board_bus_pkg::NUM_SELECTS-1:0] device_selects_n_o,
  output logic [board_bus_pkg::NUM_DIR_LINES-1:0] bank_direction_lines_o,
  output logic translator_direction_o
);
  import board_bus_pkg::*;

  function automatic logic phase_hit(input logic [7:0] a);
    phase_hit = (a == SEL_PHASE_UPPER) || (a == SEL_PHASE_LOWER);
  endfunction

  // One select per address byte value 0 to 147 (none for higher values), gated by the board select
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      device_selects_n_o <= '1;
    end else begin
      for (int k = 0; k < NUM_SELECTS; k++) begin
        device_selects_n_o[k] <= !(!board_select_n_i &&
                                   (upper_address_byte_i == k[7:0]));
      end
    end
  end

  // All bank direction lines switch together
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bank_direction_lines_o <= '0;
    end else begin
      bank_direction_lines_o <= {NUM_DIR_LINES{read_not_write_i}};
    end
  end

  // High points the translator toward the main bus
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      translator_direction_o <= 1'b0;
    end else begin
      translator_direction_o <= !board_select_n_i && read_not_write_i &&
                                phase_hit(upper_address_byte_i);
    end
  end
endmodule

// ### rtl/board_bus_control.sv
`timescale 1ns/1ps
module board_bus_control (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic interface_select_n_i,
  input wire logic read_not_write_i,
  input wire logic [board_bus_pkg::LOW_ADDR_W-1:0] low_address_i,
  input wire logic [board_bus_pkg::DATA_W-1:0] bus_data_i,
  output logic [board_bus_pkg::DATA_W-1:0] bus_data_o,
  output logic bus_data_oe_o,
  input wire logic board_select_n_i,
  input wire logic [7:0] upper_address_byte_i,
  output logic [board_bus_pkg::NUM_SELECTS-1:0] device_selects_n_o,
  output logic [board_bus_pkg::NUM_DIR_LINES-1:0] bank_direction_lines_o,
  output logic translator_direction_o,
  input wire logic [board_bus_pkg::TICK_W-1:0] tick_i,
  output logic interrupt_o,
  output logic [board_bus_pkg::ACC_RST_W-1:0] accumulator_resets_n_o,
  output logic [board_bus_pkg::DLY_RST_W-1:0] delay_loop_resets_n_o,
  output logic gigabit_unit_reset_n_o,
  output logic [board_bus_pkg::PHS_RST_W-1:0] phasing_unit_resets_n_o,
  input wire logic [board_bus_pkg::SERIAL_W-1:0] board_serial_number_i,
  input wire logic [board_bus_pkg::SLOT_ID_W-1:0] backplane_slot_id_i,
  input wire logic supplies_ok_i,
  output logic [board_bus_pkg::LAMP_W-1:0] status_lamp_drive_o,
  output logic [board_bus_pkg::FANOUT_W-1:0] bus_clock_fanout_o,
  output logic phasing_clock_copy_o
);
  import board_bus_pkg::*;

  logic [STRAP_W-1:0] strap_meta_r;
  logic [STRAP_W-1:0] strap_sync_r;
  logic [SERIAL_W-1:0] serial_s;
  logic [SLOT_ID_W-1:0] slot_s;
  logic power_s;
  logic [SEL_IDX_W-1:0] int_sel_r;
  logic [TICK_W-1:0] tick_seen_r;
  logic [TICK_W-1:0] tick_seen_nxt;
  logic [TICK_W-1:0] tick_clr;
  logic rd_active_r;
  logic wr_access;
  logic rd_access;
  logic rd_start;

  function automatic logic addr_is(input logic [4:0] a, input logic [4:0] off);
    addr_is = (a == off);
  endfunction

  function automatic logic [15:0] pad16(input logic [15:0] v);
    pad16 = v;
  endfunction

  // Bus access qualification
  assign wr_access = !interface_select_n_i && !read_not_write_i;
  assign rd_access = !interface_select_n_i && read_not_write_i;
  assign rd_start = rd_access && !rd_active_r;

  // Clock fanout passes the bus clock straight through
  assign bus_clock_fanout_o = {FANOUT_W{clock_i}};
  assign phasing_clock_copy_o = clock_i;

  // Straps and power status come from off-chip, synchronise first
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      strap_meta_r <= '0;
      strap_sync_r <= '0;
    end else begin
      strap_meta_r <= {supplies_ok_i, backplane_slot_id_i, board_serial_number_i};
      strap_sync_r <= strap_meta_r;
    end
  end

  assign serial_s = strap_sync_r[SERIAL_W-1:0];
  assign slot_s = strap_sync_r[SERIAL_W +: SLOT_ID_W];
  assign power_s = strap_sync_r[STRAP_W-1];

  // Read-back mux over the five low address bits
  function automatic logic [7:0] read_byte(
    input logic [4:0] a,
    input logic [ACC_RST_W-1:0] acc,
    input logic [DLY_RST_W-1:0] dly,
    input logic gig,
    input logic [PHS_RST_W-1:0] phs,
    input logic [SEL_IDX_W-1:0] isel,
    input logic [LAMP_W-1:0] lamp,
    input logic pwr,
    input logic [SERIAL_W-1:0] sn,
    input logic [SLOT_ID_W-1:0] slot,
    input logic [TICK_W-1:0] seen
  );
    logic [15:0] sn16;
    sn16 = pad16({2'b00, sn});
    read_byte = BYTE_ZERO;
    for (int i = 0; i < ACC_RST_BYTES; i++) begin
      if (addr_is(a, OFF_ACC_RST0 + i[4:0])) begin
        read_byte = acc[8*i +: 8];
      end
    end
    case (a)
      OFF_DLY_RST_LO: read_byte = dly[7:0];
      OFF_DLY_RST_HI: read_byte = dly[15:8];
      OFF_MISC_RST: read_byte = {5'b00000, phs, gig};
      OFF_INT_SEL: read_byte = {4'b0000, isel};
      OFF_LAMP: read_byte = {6'b000000, lamp};
      OFF_POWER: read_byte = {7'b0000000, pwr};
      OFF_SERIAL_LO: read_byte = sn16[7:0];
      OFF_SERIAL_HI: read_byte = sn16[15:8];
      OFF_SLOT_LO: read_byte = slot[7:0];
      OFF_SLOT_HI: read_byte = slot[15:8];
      OFF_TICK_LO: read_byte = seen[7:0];
      OFF_TICK_HI: read_byte = seen[15:8];
      default: ;
    endcase
  endfunction

  // Track the read so a held access is taken once
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_active_r <= 1'b0;
    end else begin
      rd_active_r <= rd_access;
    end
  end

  // Read data captured on the first cycle of the access
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_data_o <= BYTE_ZERO;
    end else if (rd_start) begin
      bus_data_o <= read_byte(low_address_i, accumulator_resets_n_o,
                              delay_loop_resets_n_o, gigabit_unit_reset_n_o,
                              phasing_unit_resets_n_o, int_sel_r, status_lamp_drive_o,
                              power_s, serial_s, slot_s, tick_seen_r);
    end
  end

  // Drive the data port one cycle behind a selected read, for as many cycles as it lasts
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_data_oe_o <= 1'b0;
    end else begin
      bus_data_oe_o <= rd_access;
    end
  end

  // Accumulator resets, one byte per column
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      accumulator_resets_n_o <= {ACC_RST_BYTES{RST_BYTE_INIT}};
    end else if (wr_access) begin
      for (int i = 0; i < ACC_RST_BYTES; i++) begin
        if (addr_is(low_address_i, OFF_ACC_RST0 + i[4:0])) begin
          accumulator_resets_n_o[8*i +: 8] <= bus_data_i;
        end
      end
    end
  end

  // Delay-loop resets, Y units low byte, X units high byte
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      delay_loop_resets_n_o <= {RST_BYTE_INIT, RST_BYTE_INIT};
    end else if (wr_access) begin
      if (addr_is(low_address_i, OFF_DLY_RST_LO)) begin
        delay_loop_resets_n_o[7:0] <= bus_data_i;
      end
      if (addr_is(low_address_i, OFF_DLY_RST_HI)) begin
        delay_loop_resets_n_o[15:8] <= bus_data_i;
      end
    end
  end

  // Gigabit and phasing unit resets
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gigabit_unit_reset_n_o <= RST_BYTE_INIT[0];
      phasing_unit_resets_n_o <= RST_BYTE_INIT[PHS_RST_W-1:0];
    end else if (wr_access && addr_is(low_address_i, OFF_MISC_RST)) begin
      gigabit_unit_reset_n_o <= bus_data_i[BIT_GIGABIT_RST];
      phasing_unit_resets_n_o <= bus_data_i[BIT_PHASE_RST0 +: PHS_RST_W];
    end
  end

  // Interrupt source select
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_sel_r <= INT_SEL_INIT;
    end else if (wr_access && addr_is(low_address_i, OFF_INT_SEL)) begin
      int_sel_r <= bus_data_i[SEL_IDX_W-1:0];
    end
  end

  // Status lamp, code written straight to the drive lines
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      status_lamp_drive_o <= LAMP_OFF;
    end else if (wr_access && addr_is(low_address_i, OFF_LAMP)) begin
      status_lamp_drive_o <= bus_data_i[LAMP_W-1:0];
    end
  end

  // Selected tick forwarded with one cycle of latency; pulse width kept
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_o <= 1'b0;
    end else begin
      interrupt_o <= tick_i[int_sel_r];
    end
  end

  // Sticky tick flags, cleared per byte when read, a new tick wins
  always_comb begin
    tick_clr = '0;
    if (rd_start && addr_is(low_address_i, OFF_TICK_LO)) begin
      tick_clr[7:0] = 8'hFF;
    end
    if (rd_start && addr_is(low_address_i, OFF_TICK_HI)) begin
      tick_clr[15:8] = 8'hFF;
    end
    tick_seen_nxt = (tick_seen_r & ~tick_clr) | tick_i;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tick_seen_r <= '0;
    end else begin
      tick_seen_r <= tick_seen_nxt;
    end
  end

  // Address decode part
  bus_decode u_decode (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .board_select_n_i(board_select_n_i),
    .upper_address_byte_i(upper_address_byte_i),
    .read_not_write_i(read_not_write_i),
    .device_selects_n_o(device_selects_n_o),
    .bank_direction_lines_o(bank_direction_lines_o),
    .translator_direction_o(translator_direction_o)
  );
endmodule

// ### tb/board_bus_control_props.sv
`timescale 1ns/1ps
module board_bus_control_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic interface_select_n_i,
  input wire logic read_not_write_i,
  input wire logic board_select_n_i,
  input wire logic [7:0] upper_address_byte_i,
  input wire logic [board_bus_pkg::TICK_W-1:0] tick_i,
  input wire logic bus_data_oe_o,
  input wire logic interrupt_o,
  input wire logic [board_bus_pkg::NUM_SELECTS-1:0] device_selects_n_o,
  input wire logic [board_bus_pkg::NUM_DIR_LINES-1:0] bank_direction_lines_o,
  input wire logic translator_direction_o
);
  import board_bus_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic phs_rd;
  assign phs_rd = !board_select_n_i && read_not_write_i && upper_address_byte_i[7:1] == 7'h49;
  sel_idle_a: assert property (board_select_n_i |=> &device_selects_n_o)
    else $error("select active without board select");
  sel_decode_a: assert property (!board_select_n_i |=>
    device_selects_n_o == ~(148'h1 << $past(upper_address_byte_i)))
    else $error("wrong select for upper address byte");
  dir_same_a: assert property (1'b1 |=>
    bank_direction_lines_o == {NUM_DIR_LINES{$past(read_not_write_i)}})
    else $error("direction lines differ from direction input");
  trans_dir_a: assert property (1'b1 |=> translator_direction_o == $past(phs_rd))
    else $error("translator direction wrong");
  irq_cause_a: assert property (interrupt_o |-> $past(|tick_i))
    else $error("interrupt without tick");
  oe_cause_a: assert property (bus_data_oe_o |->
    $past(!interface_select_n_i && read_not_write_i))
    else $error("data driven outside read");
  rd_answer_a: assert property (!interface_select_n_i && read_not_write_i |=> bus_data_oe_o)
    else $error("read not answered");
  oe_release_a: assert property (interface_select_n_i |=> !bus_data_oe_o)
    else $error("data driven while unselected");
  cover property (phs_rd);
  cover property (interrupt_o);
  cover property ($fell(bus_data_oe_o));
endmodule
bind board_bus_control board_bus_control_props board_bus_control_props_i (
  .clock_i(clock_i), .rst_i(rst_i), .interface_select_n_i(interface_select_n_i),
  .read_not_write_i(read_not_write_i), .board_select_n_i(board_select_n_i),
  .upper_address_byte_i(upper_address_byte_i), .tick_i(tick_i), .bus_data_oe_o(bus_data_oe_o),
  .interrupt_o(interrupt_o), .device_selects_n_o(device_selects_n_o),
  .bank_direction_lines_o(bank_direction_lines_o),
  .translator_direction_o(translator_direction_o));

// ### tb/host_bridge_model.sv
`timescale 1ns/1ps
module host_bridge_model (
  input wire logic clock_i,
  input wire logic [7:0] dout_i,
  input wire logic oe_i,
  output logic bs_n_o,
  output logic if_sel_n_o,
  output logic rnw_o,
  output logic [15:0] addr_o,
  output logic [7:0] data_o
);
  logic drv = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] last = 8'h00;
  initial begin
    bs_n_o = 1'b1;
    if_sel_n_o = 1'b1;
    rnw_o = 1'b0;
    addr_o = 16'h0000;
  end
  // Floating pin shows a changing pattern
  assign data_o = oe_i ? dout_i : (drv ? wdata : ~last);
  always_ff @(posedge clock_i) begin
    last <= data_o;
  end
  task automatic cycle(input logic bs_n, input logic [15:0] a, input logic rnw,
                       input logic wr, input logic [7:0] d, input int holds,
                       output logic [7:0] q);
    @(negedge clock_i);
    bs_n_o = bs_n;
    if_sel_n_o = bs_n | (a[15:8] != 8'h00);
    rnw_o = rnw;
    addr_o = a;
    drv = wr;
    wdata = d;
    repeat (holds) @(posedge clock_i);
    q = data_o;
    @(negedge clock_i);
    bs_n_o = 1'b1;
    if_sel_n_o = 1'b1;
    rnw_o = 1'b0;
    drv = 1'b0;
  endtask
endmodule

// ### tb/board_bus_control_test.sv
`timescale 1ns/1ps
module board_bus_control_test;
  logic clock_i, rst_i, pwr, bs_n, if_n, rnw, oe, irq, gig, trd, pclk;
  logic [15:0] tick_i, slot, a, t, addr, dly, seen;
  logic [13:0] sn;
  logic [7:0] q, din, dout, v [11];
  logic [1:0] b, phs, lamp;
  logic [63:0] ea, acc;
  logic [147:0] sel;
  logic [18:0] dir;
  logic [30:0] fan;
  logic [7:0] corner [4] = '{8'h92, 8'h93, 8'h94, 8'hff};
  int i, seed, mismatches = 0, tests_run = 0;
  board_bus_control board_bus_control_i (.clock_i(clock_i), .rst_i(rst_i),
    .interface_select_n_i(if_n), .read_not_write_i(rnw), .low_address_i(addr[4:0]),
    .bus_data_i(din), .bus_data_o(dout), .bus_data_oe_o(oe), .board_select_n_i(bs_n),
    .upper_address_byte_i(addr[15:8]), .device_selects_n_o(sel), .bank_direction_lines_o(dir),
    .translator_direction_o(trd), .tick_i(tick_i), .interrupt_o(irq),
    .accumulator_resets_n_o(acc), .delay_loop_resets_n_o(dly), .gigabit_unit_reset_n_o(gig),
    .phasing_unit_resets_n_o(phs), .board_serial_number_i(sn), .backplane_slot_id_i(slot),
    .supplies_ok_i(pwr), .status_lamp_drive_o(lamp), .bus_clock_fanout_o(fan),
    .phasing_clock_copy_o(pclk));
  host_bridge_model host_bridge_model_i (.clock_i(clock_i), .dout_i(dout), .oe_i(oe),
    .bs_n_o(bs_n), .if_sel_n_o(if_n), .rnw_o(rnw), .addr_o(addr), .data_o(din));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [147:0] got, input logic [147:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] wa, input logic [7:0] d);
    host_bridge_model_i.cycle(1'b0, wa, 1'b0, 1'b1, d, 1, q);
  endtask
  task automatic rd_chk(input logic [15:0] ra, input logic [7:0] e);
    host_bridge_model_i.cycle(1'b0, ra, 1'b1, 1'b0, 8'h00, 3, q);
    chk(q, e);
  endtask
  task automatic pulse(input logic [15:0] p, input logic e);
    @(negedge clock_i);
    tick_i = p;
    @(negedge clock_i);
    tick_i = 16'h0000;
    chk(irq, e);
  endtask
  function automatic logic [147:0] exp_sel(input logic n, input logic [7:0] up);
    exp_sel = '1;
    if (!n && up < 8'h94) exp_sel[up] = 1'b0;
  endfunction
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    end_sim;
  end
  initial begin
    seed = 32'h5a22_6168;
    rst_i = 1'b1;
    tick_i = 16'h0000;
    sn = $random(seed);
    slot = $random(seed);
    pwr = $random(seed);
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    chk({acc, dly, gig, phs, lamp, oe, irq}, 0);
    #1 chk({fan, pclk}, 0);
    @(posedge clock_i);
    #1 chk({fan, pclk}, 32'hffff_ffff);
    $display("test reset done");
    for (i = 0; i < 11; i++) begin
      v[i] = $random(seed);
      wr(i[15:0], v[i]);
      if (i < 8) ea[8*i+:8] = v[i];
    end
    chk(acc, ea);
    chk(dly, {v[9], v[8]});
    chk({gig, phs}, {v[10][0], v[10][2:1]});
    chk(oe, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(16'h000c, i[7:0]);
      chk(lamp, i[1:0]);
    end
    wr(16'h010c, 8'h01);
    chk(lamp, 2'b11);
    @(negedge clock_i);
    rst_i = 1'b1;
    #1 chk({acc, dly, gig, phs, lamp, oe, irq}, 0);
    @(negedge clock_i);
    rst_i = 1'b0;
    $display("test reset lines and lamp done");
    wr(16'h0010, 8'hff);
    rd_chk(16'h0010, sn[7:0]);
    rd_chk(16'h0011, {2'b00, sn[13:8]});
    rd_chk(16'h0012, slot[7:0]);
    rd_chk(16'h0013, slot[15:8]);
    rd_chk(16'h000d, {7'h00, pwr});
    rd_chk(16'h001f, 8'h00);
    $display("test readback done");
    seen = 16'h0000;
    for (i = 0; i < 16; i++) begin
      wr(16'h000b, i[7:0]);
      t = $random(seed);
      t[i] = 1'b1;
      seen = seen | t;
      pulse(t, 1'b1);
      t[i] = 1'b0;
      pulse(t, 1'b0);
    end
    rd_chk(16'h0014, seen[7:0]);
    rd_chk(16'h0014, 8'h00);
    rd_chk(16'h0015, seen[15:8]);
    $display("test interrupt select done");
    for (i = 0; i < 300; i++) begin
      a = $random(seed);
      b = $random(seed);
      if (i < 4) a[15:8] = corner[i];
      if (i < 4) b = 2'b10;
      host_bridge_model_i.cycle(b[0], a, b[1], !b[1], 8'h00, b[1] ? 3 : 1, q);
      chk(sel, exp_sel(b[0], a[15:8]));
      chk(dir, {19{b[1]}});
      chk(trd, !b[0] && b[1] && a[15:9] == 7'h49);
    end
    $display("test decode done");
    end_sim;
  end
endmodule
